//--- hdl/sar_adc_core_control.sv
`timescale 1ns/1ps
// Contract
// R01: result is 10 bits; full scale 3ff at/above top, zero at/below bottom.
// R02: result coded unsigned binary or two's complement per format bit.
// R03: binary code equals 1023 times input over span.
// R04: core runs only while power-on bit is set.
// R05: configuration writes take effect only while conversion enable is 0; the polarity bit is written at any time.
// R06: no conversion starts unless conversion enable was set beforehand.
// R07: one conversion clock drives both sampling timer and approximation steps.
// R08: conversion clock is source divided by 1 to 8.
// R09: four selectable clock sources.
// R10: software keeps the conversion clock running until conversion ends.
// R11: multiplexer selects one of eight external and four internal channels.
// R12: break-before-make: old switch opens before new closes.
// R13: unselected channels isolated, intermediate node grounded.
// R14: analog enable bit disables both pin buffers.
// R15: software leaves enables of absent pins at default.
// R16: each result is pushed to the transfer controller automatically.
// R17: conversion starts on rising trigger edge, selectable source and polarity.
// R18: sample window high 4, 8, 16 or 64 conversion clocks after sync.
// R19: falling sample window edge starts a 13-clock conversion.
// R20: sequence mode selects single, sequence, repeat single, repeat sequence.
// R21: result register holds last result until the next one completes.
module sar_adc_core_control
  import sar_ctl_pkg::*;
#(
  parameter int PIN_EN_W = 16
) (
  // clock and reset
  input  wire logic                CLK_SYS,
  input  wire logic                RST,
  // configuration
  input  wire logic                CONVERTER_POWER_ON,
  input  wire logic                CONVERSION_ENABLE,
  input  wire logic                CFG_WRITE,
  input  wire logic [1:0]          CONV_CLOCK_SOURCE_SELECT,
  input  wire logic [2:0]          CONV_CLOCK_DIVIDER,
  input  wire logic [3:0]          CHANNEL_SELECT,
  input  wire logic [1:0]          SEQUENCE_MODE_SELECT,
  input  wire logic [1:0]          SAMPLE_PERIOD_SELECT,
  input  wire logic [1:0]          TRIGGER_SOURCE_SELECT,
  input  wire logic                TRIGGER_POLARITY_INVERT,
  input  wire logic                RESULT_TWOS_COMPLEMENT,
  input  wire logic [PIN_EN_W-1:0] ANALOG_PIN_ENABLE,
  // clock sources, one-cycle enables in the system clock
  input  wire logic                SUB_MAIN_SYSTEM_CLOCK,
  input  wire logic                MAIN_SYSTEM_CLOCK,
  input  wire logic                AUX_CLOCK,
  input  wire logic                INTERNAL_CONV_OSCILLATOR,
  // triggers and core comparator
  input  wire logic [3:0]          SAMPLE_TRIGGER_INPUT,
  input  wire logic                COMPARATOR_OUT,
  // multiplexer and pins
  output logic [NUM_CH-1:0]        CHANNEL_SWITCH_CLOSED,
  output logic [NUM_CH-1:0]        CHANNEL_NODE_GROUNDED,
  output logic [PIN_EN_W-1:0]      PIN_INPUT_BUFFER_DISABLE,
  output logic [PIN_EN_W-1:0]      PIN_OUTPUT_BUFFER_DISABLE,
  // core
  output logic                     CORE_POWERED,
  output logic                     SAMPLE_WINDOW_SIGNAL,
  output logic [RESULT_W-1:0]      SAR_TRIAL_CODE,
  output logic                     CONVERSION_BUSY,
  // result
  output logic [RESULT_W-1:0]      CONVERSION_RESULT_REG,
  output logic                     RESULT_TRANSFER_VALID
);

  // -------------------------------------------------------------------------
  // elaboration checks
  // -------------------------------------------------------------------------
  if (PIN_EN_W < 1 || PIN_EN_W > 32) begin : g_pin_w_chk
    $error("PIN_EN_W out of range");
  end
  // channel field is four bits, trial and result are ten
  if (NUM_CH > 16 || RESULT_W != 10) begin : g_width_chk
    $error("channel or result width not served");
  end
  // settle tail must follow the bit steps and fit the 7-bit counter
  if (CONV_CYCLES <= RESULT_W || CONV_CYCLES > 127) begin : g_conv_chk
    $error("conversion length not served");
  end
  // a zero period would only match once the count that starts at one wraps round to zero
  if (SAMPLE_P0 == 7'h00 || SAMPLE_P1 == 7'h00 || SAMPLE_P2 == 7'h00 ||
      SAMPLE_P3 == 7'h00) begin : g_sample_chk
    $error("sample period must be nonzero");
  end

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {IDLE, SAMPLE, CONVERT, SWITCH_OPEN, DONE} phase_t;

  typedef struct packed {
    logic [1:0]          src;
    logic [2:0]          div;
    logic [3:0]          ch;
    logic [1:0]          seq;
    logic [1:0]          sht;
    logic [1:0]          trig_src;
    logic                trig_inv;
    logic                twos;
    logic [2:0]          div_cnt;
    logic                trig_s1;
    logic                trig_s2;
    logic                trig_prev;
    logic                armed;
    phase_t              phase;
    logic [6:0]          cnt;
    logic [3:0]          cur_ch;
    logic [3:0]          mux_ch;
    logic                mux_on;
    logic [9:0]          trial;
    logic [9:0]          result;
    logic                push;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic        src_tick;
  logic        cclk;
  logic        trig_level;
  logic        trig_rise;
  logic [6:0]  sample_len;
  logic [3:0]  bit_idx;
  logic [9:0]  coded;

  // -------------------------------------------------------------------------
  // conversion clock and trigger
  // -------------------------------------------------------------------------
  always_comb begin
    case (s_reg.src)                                            // R09
      2'h0:    src_tick = SUB_MAIN_SYSTEM_CLOCK;
      2'h1:    src_tick = MAIN_SYSTEM_CLOCK;
      2'h2:    src_tick = AUX_CLOCK;
      default: src_tick = INTERNAL_CONV_OSCILLATOR;
    endcase
    // one enable pulse every div+1 source ticks; >= keeps a shrunk divider
    // from running the counter round once before it settles
    cclk = src_tick && (s_reg.div_cnt >= s_reg.div);           // R08
    trig_level = s_reg.trig_s2 ^ s_reg.trig_inv;                // R17
    trig_rise = trig_level && !s_reg.trig_prev;
  end

  // -------------------------------------------------------------------------
  // sample length and result coding
  // -------------------------------------------------------------------------
  always_comb begin
    case (s_reg.sht)                                            // R18
      2'h0:    sample_len = SAMPLE_P0;
      2'h1:    sample_len = SAMPLE_P1;
      2'h2:    sample_len = SAMPLE_P2;
      default: sample_len = SAMPLE_P3;
    endcase
    bit_idx = 4'(RESULT_W - 1) - s_reg.cnt[3:0];
    // offset binary to two's complement is a flip of the top bit
    coded = s_reg.twos ? {~s_reg.trial[9], s_reg.trial[8:0]} : s_reg.trial; // R02
  end

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.push = 1'b0;
    if (!CONVERSION_ENABLE && CFG_WRITE) begin                  // R05
      s_next.src      = CONV_CLOCK_SOURCE_SELECT;
      s_next.div      = CONV_CLOCK_DIVIDER;
      s_next.ch       = CHANNEL_SELECT;
      s_next.seq      = SEQUENCE_MODE_SELECT;
      s_next.sht      = SAMPLE_PERIOD_SELECT;
      s_next.trig_src = TRIGGER_SOURCE_SELECT;
      s_next.twos     = RESULT_TWOS_COMPLEMENT;
    end
    // polarity is the only bit writable at any time
    if (CFG_WRITE) begin
      s_next.trig_inv = TRIGGER_POLARITY_INVERT;
    end
    s_next.trig_s1 = SAMPLE_TRIGGER_INPUT[s_reg.trig_src];
    s_next.trig_s2 = s_reg.trig_s1;
    if (src_tick) begin
      s_next.div_cnt = cclk ? 3'h0 : s_reg.div_cnt + 3'h1;
    end
    if (cclk) begin                                             // R07
      s_next.trig_prev = trig_level;
    end
    if (!CONVERTER_POWER_ON) begin                              // R04
      s_next.phase  = IDLE;
      s_next.mux_on = 1'b0;
      s_next.cnt    = 7'h00;
    end else if (cclk) begin
      unique case (s_reg.phase)
        IDLE: begin
          if (CONVERSION_ENABLE && s_reg.armed && trig_rise) begin // R06 R17
            s_next.phase  = SWITCH_OPEN;
            s_next.cur_ch = s_reg.ch;
            s_next.mux_on = 1'b0;
          end
        end
        SWITCH_OPEN: begin
          // open for a full conversion clock before closing the new switch
          s_next.mux_ch = s_reg.cur_ch;                        // R12
          s_next.mux_on = 1'b1;
          s_next.phase  = SAMPLE;
          s_next.cnt    = 7'h01;
        end
        SAMPLE: begin
          if (s_reg.cnt == sample_len) begin                    // R18
            s_next.phase  = CONVERT;
            s_next.cnt    = 7'h00;
            s_next.mux_on = 1'b0;
            s_next.trial  = 10'h200;
          end else begin
            s_next.cnt = s_reg.cnt + 7'h01;
          end
        end
        CONVERT: begin
          // cycles 0..9 resolve bits 9..0, remainder is settle time
          if (s_reg.cnt < 7'(RESULT_W)) begin                   // R03
            if (!COMPARATOR_OUT) begin
              s_next.trial[bit_idx] = 1'b0;
            end
            if (bit_idx != 4'h0) begin
              s_next.trial[bit_idx - 4'h1] = 1'b1;
            end
          end
          if (s_reg.cnt == 7'(CONV_CYCLES - 1)) begin           // R19
            s_next.phase = DONE;
          end else begin
            s_next.cnt = s_reg.cnt + 7'h01;
          end
        end
        DONE: begin
          s_next.result = coded;                                // R01 R21
          s_next.push   = 1'b1;                                 // R16
          s_next.phase  = IDLE;
          if (s_reg.seq[0] && s_reg.cur_ch != 4'h0) begin       // R20
            s_next.cur_ch = s_reg.cur_ch - 4'h1;
            s_next.phase  = SWITCH_OPEN;
          end else if (s_reg.seq[1] && CONVERSION_ENABLE) begin
            s_next.cur_ch = s_reg.ch;
            s_next.phase  = s_reg.seq[0] ? IDLE : SWITCH_OPEN;
          end else if (!s_reg.seq[1]) begin
            s_next.armed = 1'b0;
          end
        end
      endcase
    end
    // the once modes (single and sequence) need enable toggled between runs; the re-arm comes
    // last so an enable drop in the done cycle wins over the disarm
    if (!CONVERSION_ENABLE) begin                               // R06
      s_next.armed = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_reg <= '{
        src:       SRC_RST,
        div:       DIV_RST,
        ch:        CH_RST,
        seq:       SEQ_SINGLE_ONCE,
        sht:       2'h0,
        trig_src:  2'h0,
        trig_inv:  1'b0,
        twos:      1'b0,
        div_cnt:   3'h0,
        trig_s1:   1'b0,
        trig_s2:   1'b0,
        trig_prev: 1'b0,
        armed:     1'b1,
        phase:     IDLE,
        cnt:       7'h00,
        cur_ch:    CH_RST,
        mux_ch:    CH_RST,
        mux_on:    1'b0,
        trial:     RESULT_RST,
        result:    RESULT_RST,
        push:      1'b0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // -------------------------------------------------------------------------
  // multiplexer outputs
  // -------------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      CHANNEL_SWITCH_CLOSED[i] = s_reg.mux_on && (s_reg.mux_ch == 4'(i)); // R11 R12
      CHANNEL_NODE_GROUNDED[i] = !CHANNEL_SWITCH_CLOSED[i];              // R13
    end
  end

  // -------------------------------------------------------------------------
  // pin buffers and status
  // -------------------------------------------------------------------------

  assign PIN_INPUT_BUFFER_DISABLE  = ANALOG_PIN_ENABLE;                 // R14
  assign PIN_OUTPUT_BUFFER_DISABLE = ANALOG_PIN_ENABLE;                 // R14
  assign CORE_POWERED              = CONVERTER_POWER_ON;                // R04
  assign SAMPLE_WINDOW_SIGNAL      = s_reg.mux_on && (s_reg.phase == SAMPLE);
  assign SAR_TRIAL_CODE            = s_reg.trial;
  assign CONVERSION_BUSY           = (s_reg.phase != IDLE);
  assign CONVERSION_RESULT_REG     = s_reg.result;
  assign RESULT_TRANSFER_VALID     = s_reg.push;

endmodule

//--- hdl/sar_ctl_pkg.sv
package sar_ctl_pkg;

  // -------------------------------------------------------------------------
  // result coding
  // -------------------------------------------------------------------------
  localparam int          RESULT_W      = 10;
  localparam logic [9:0]  RESULT_FULL   = 10'h3ff;
  localparam logic [9:0]  RESULT_RST    = 10'h000;
  localparam int          CONV_CYCLES   = 13;

  // -------------------------------------------------------------------------
  // channels and clocks
  // -------------------------------------------------------------------------
  localparam int          NUM_EXT_CH    = 8;
  localparam int          NUM_INT_CH    = 4;
  localparam int          NUM_CH        = NUM_EXT_CH + NUM_INT_CH;
  localparam int          NUM_SRC       = 4;
  localparam logic [3:0]  CH_RST        = 4'h0;
  localparam logic [2:0]  DIV_RST       = 3'h0;
  localparam logic [1:0]  SRC_RST       = 2'h0;

  // sample period codes map to 4, 8, 16, 64 conversion clocks
  localparam logic [6:0]  SAMPLE_P0     = 7'h04;
  localparam logic [6:0]  SAMPLE_P1     = 7'h08;
  localparam logic [6:0]  SAMPLE_P2     = 7'h10;
  localparam logic [6:0]  SAMPLE_P3     = 7'h40;

  typedef enum logic [1:0] {
    SEQ_SINGLE_ONCE = 2'b00,
    SEQ_SEQ_ONCE    = 2'b01,
    SEQ_SINGLE_REP  = 2'b10,
    SEQ_SEQ_REP     = 2'b11
  } seq_mode_t;

endpackage

//--- verification/sar_adc_core_control_tb.sv
`timescale 1ns/1ps
module sar_adc_core_control_tb;
  import sar_ctl_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic        clk = 0, rst = 1, pwr = 1, en = 0, cw = 0, inv = 0, twos = 0;
  logic [1:0]  src = 0, mode = 0, shp = 0, tsel = 0;
  logic [2:0]  div = 0;
  logic [3:0]  ch = 0, trig = 0, tick;
  logic [15:0] ape = 16'h05c3, ibd, obd; // pins 12 to 15 absent, left at 0
  logic [9:0]  vin = 0, trial, res;
  logic [11:0] sw, gnd;
  logic        cmp, win, vld, busy, cpw;
  int miscompares = 0, n_tests = 0, cyc = 0, hi = 0, width = 0, nv = 0, n0, w_exp;
  int dv[4] = '{0, 2, 7, 1};
  int sp[4] = '{4, 8, 16, 64};
  int ex[4] = '{0, 'h3ff, 'h155, 'h355};
  int lo[4] = '{1, 2, 5, 8};
  int up[4] = '{1, 2, 99, 8};
  sar_adc_core_control sar_adc_core_control_i (
    .CLK_SYS(clk), .RST(rst), .CONVERTER_POWER_ON(pwr), .CONVERSION_ENABLE(en),
    .CFG_WRITE(cw), .CONV_CLOCK_SOURCE_SELECT(src), .CONV_CLOCK_DIVIDER(div),
    .CHANNEL_SELECT(ch), .SEQUENCE_MODE_SELECT(mode), .SAMPLE_PERIOD_SELECT(shp),
    .TRIGGER_SOURCE_SELECT(tsel), .TRIGGER_POLARITY_INVERT(inv),
    .RESULT_TWOS_COMPLEMENT(twos), .ANALOG_PIN_ENABLE(ape),
    .SUB_MAIN_SYSTEM_CLOCK(tick[0]), .MAIN_SYSTEM_CLOCK(tick[1]), .AUX_CLOCK(tick[2]),
    .INTERNAL_CONV_OSCILLATOR(tick[3]), .SAMPLE_TRIGGER_INPUT(trig), .COMPARATOR_OUT(cmp),
    .CHANNEL_SWITCH_CLOSED(sw), .CHANNEL_NODE_GROUNDED(gnd), .PIN_INPUT_BUFFER_DISABLE(ibd),
    .PIN_OUTPUT_BUFFER_DISABLE(obd), .CORE_POWERED(cpw), .SAMPLE_WINDOW_SIGNAL(win),
    .SAR_TRIAL_CODE(trial), .CONVERSION_BUSY(busy), .CONVERSION_RESULT_REG(res),
    .RESULT_TRANSFER_VALID(vld));
  sar_analog_source sar_analog_source_i (.level(vin), .trial(trial), .above(cmp));
  initial forever #25 clk = ~clk;
  // sources tick all run long, so no conversion loses its clock
  always @(negedge clk) cyc <= cyc + 1;
  always_comb for (int k = 0; k < 4; k++) tick[k] = (cyc % (k + 1)) == 0;
  always @(posedge clk) begin
    if (win) hi <= hi + 1;
    else if (hi != 0) begin
      width <= hi;
      hi <= 0;
    end
    if (vld) nv <= nv + 1;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t code %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int mn, input int mx);
    n_tests++;
    if (got < mn || got > mx) begin
      miscompares++;
      $display("[ERR] %0t count %0d outside %0d..%0d", $time, got, mn, mx);
    end
  endtask
  task automatic cfg(input int s, input int d, input int c, input int m, input int p);
    @(negedge clk) en = 0;
    src = 2'(s);
    div = 3'(d);
    ch = 4'(c);
    mode = 2'(m);
    shp = 2'(p);
    tsel = 2'(m);
    trig = {4{inv}};
    cw = 1;
    @(negedge clk) cw = 0;
    // idle ticks let the trigger history settle before arming
    repeat (8) @(negedge clk);
    en = 1;
  endtask
  task automatic fire;
    @(negedge clk) trig[tsel] = ~inv;
    repeat (40) @(negedge clk);
    trig[tsel] = inv;
  endtask
  task automatic wait_nv;
    repeat (4000) if (nv == n0) @(negedge clk);
    chk_n(nv - n0, 1, 1);
  endtask
  task automatic stop_test;
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(60000 * 50);
    miscompares++;
    $display("[ERR] %0t run hung", $time);
    stop_test;
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    chk(ibd, ape);
    chk(obd, ape);
    for (int k = 0; k < 4; k++) begin
      cfg(k, dv[k], 0, 0, k);
      n0 = nv;
      fire;
      wait_nv;
      w_exp = sp[k] * (k + 1) * (dv[k] + 1);
      chk_n(width, w_exp, w_exp);
    end
    for (int k = 0; k < 4; k++) begin
      vin = 10'(ex[k] & 'h3ff) ^ {k == 3, 9'h0};
      twos = (k == 3);
      cfg(0, 0, 0, 0, 0);
      n0 = nv;
      fire;
      wait_nv;
      chk({6'h0, res}, 16'(ex[k]));
    end
    cfg(0, 0, 3, 0, 0);
    @(negedge clk) ch = 5;
    cw = 1;
    @(negedge clk) cw = 0;
    n0 = nv;
    fork
      fire;
      begin
        @(posedge win);
        @(negedge clk);
        chk({4'h0, sw}, 16'h0008);
        chk({4'h0, gnd}, 16'h0ff7);
      end
    join
    wait_nv;
    for (int k = 0; k < 2; k++) begin
      cfg(0, 0, 0, 0, 0);
      @(negedge clk) en = k[0];
      pwr = !k[0];
      n0 = nv;
      fire;
      repeat (200) @(negedge clk);
      chk_n(nv - n0, 0, 0);
      chk({15'h0, busy}, 16'h0000);
      chk({15'h0, cpw}, 16'(1 - k));
      pwr = 1;
    end
    inv = 1;
    for (int m = 0; m < 4; m++) begin
      cfg(0, 0, 1, m, 0);
      n0 = nv;
      repeat (4) begin
        fire;
        repeat (60) @(negedge clk);
      end
      chk_n(nv - n0, lo[m], up[m]);
      @(negedge clk) en = 0;
      repeat (60) @(negedge clk);
    end
    stop_test;
  end
endmodule

//--- verification/sar_analog_source.sv
`timescale 1ns/1ps
module sar_analog_source
  import sar_ctl_pkg::*;
(
  // analog level as ideal code, and comparator answer
  input  wire logic [RESULT_W-1:0] level,
  input  wire logic [RESULT_W-1:0] trial,
  output logic                     above
);
  // ideal comparator, no offset, so the code equals the level
  assign above = (level >= trial);
endmodule

//--- verification/sar_ctl_asserts.sv
`timescale 1ns/1ps
module sar_ctl_asserts
  import sar_ctl_pkg::*;
#(
  parameter int PIN_EN_W = 16
) (
  // clock and reset
  input wire logic                CLK_SYS,
  input wire logic                RST,
  // watched ports
  input wire logic                CONVERTER_POWER_ON,
  input wire logic                CONVERSION_ENABLE,
  input wire logic [PIN_EN_W-1:0] ANALOG_PIN_ENABLE,
  input wire logic [NUM_CH-1:0]   CHANNEL_SWITCH_CLOSED,
  input wire logic [NUM_CH-1:0]   CHANNEL_NODE_GROUNDED,
  input wire logic [PIN_EN_W-1:0] PIN_INPUT_BUFFER_DISABLE,
  input wire logic [PIN_EN_W-1:0] PIN_OUTPUT_BUFFER_DISABLE,
  input wire logic                CORE_POWERED,
  input wire logic                SAMPLE_WINDOW_SIGNAL,
  input wire logic                CONVERSION_BUSY,
  input wire logic [RESULT_W-1:0] CONVERSION_RESULT_REG,
  input wire logic                RESULT_TRANSFER_VALID
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  in_buf_a: assert property (PIN_INPUT_BUFFER_DISABLE == ANALOG_PIN_ENABLE)
    else $error("input buffer disable wrong");
  out_buf_a: assert property (PIN_OUTPUT_BUFFER_DISABLE == ANALOG_PIN_ENABLE)
    else $error("output buffer disable wrong");
  power_follow_a: assert property (CORE_POWERED == CONVERTER_POWER_ON)
    else $error("core power not following");
  power_idle_a: assert property (!CONVERTER_POWER_ON |=> !CONVERSION_BUSY)
    else $error("busy while unpowered");
  node_ground_a: assert property (CHANNEL_NODE_GROUNDED == ~CHANNEL_SWITCH_CLOSED)
    else $error("open channel node not grounded");
  one_switch_a: assert property ($onehot0(CHANNEL_SWITCH_CLOSED))
    else $error("two switches closed");
  break_make_a: assert property ((CHANNEL_SWITCH_CLOSED != 0) ##1
    (CHANNEL_SWITCH_CLOSED != 0) |-> $stable(CHANNEL_SWITCH_CLOSED))
    else $error("switch moved without opening");
  start_enable_a: assert property ($rose(CONVERSION_BUSY) |-> $past(CONVERSION_ENABLE))
    else $error("conversion without enable");
  conv_len_a: assert property ($fell(SAMPLE_WINDOW_SIGNAL) |->
    (CONVERSION_BUSY && !RESULT_TRANSFER_VALID) [*8])
    else $error("conversion ended early");
  window_busy_a: assert property (SAMPLE_WINDOW_SIGNAL |-> CONVERSION_BUSY)
    else $error("sample window while idle");
  valid_pulse_a: assert property (RESULT_TRANSFER_VALID |=> !RESULT_TRANSFER_VALID)
    else $error("valid longer than one cycle");
  result_hold_a: assert property ($changed(CONVERSION_RESULT_REG) |->
    RESULT_TRANSFER_VALID || $past(RESULT_TRANSFER_VALID))
    else $error("result changed without completion");
endmodule
bind sar_adc_core_control sar_ctl_asserts #(.PIN_EN_W(PIN_EN_W)) chk_i (
  .CLK_SYS(CLK_SYS), .RST(RST), .CONVERTER_POWER_ON(CONVERTER_POWER_ON),
  .CONVERSION_ENABLE(CONVERSION_ENABLE), .ANALOG_PIN_ENABLE(ANALOG_PIN_ENABLE),
  .CHANNEL_SWITCH_CLOSED(CHANNEL_SWITCH_CLOSED), .CORE_POWERED(CORE_POWERED),
  .CHANNEL_NODE_GROUNDED(CHANNEL_NODE_GROUNDED),
  .PIN_INPUT_BUFFER_DISABLE(PIN_INPUT_BUFFER_DISABLE),
  .PIN_OUTPUT_BUFFER_DISABLE(PIN_OUTPUT_BUFFER_DISABLE),
  .SAMPLE_WINDOW_SIGNAL(SAMPLE_WINDOW_SIGNAL), .CONVERSION_BUSY(CONVERSION_BUSY),
  .CONVERSION_RESULT_REG(CONVERSION_RESULT_REG),
  .RESULT_TRANSFER_VALID(RESULT_TRANSFER_VALID));
